// >>> hdl/adcf_converter.sv
// Converter control: SAR clock divider, repeat accumulation, result formatting and register access.
// How it works
// - SAR clock toggles once every divisor+1 source ticks.
// - Source is system clock, or a burst tick of system clock divided by 7, under 30 MHz.
// - Repeat field sets conversions per completion event.
// - Codes 00..11 select 1, 4, 8, 16.
// - Burst runs the whole set from one start.
// - Accumulated sum goes into high:low data bytes.
// - Right justified high byte zero-filled above sum bit 11, 12, 13 for codes 00, 01, 10.
// - Code 11 high byte holds sum bits 15:8.
// - Left justified high byte is result 11:4.
// - Right justified low byte is sum 7:0.
// - Left justified low byte is bits 3:0, zeros.
// - Configuration bit 0 is the gain enable.
// - Done flag sets per finished set, sticky.
// - Control bit 6 selects burst mode.
`timescale 1ns/1ps
`include "adcf_consts.svh"
module adcf_converter
(
   input wire logic mclk,
   input wire logic reset,
   input wire adcf_pkg::adcf_sfr_req_t sfr_req,
   input wire logic convert_start,
   input wire logic [11:0] sample_code,
   input wire logic window_hit,
   output logic [7:0] sfr_rdata,
   output logic end_of_conversion_event,
   output logic window_compare_event,
   output logic sar_conversion_clock,
   output logic gain_program_enable
);
   import adcf_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);

   adcf_cfg_t converter_config_reg;
   logic converter_enable, burst_mode_enable, conversion_done_flag, window_flag, left_justify_select;
   logic [1:0] start_mode, rpt_code;
   logic [7:0] result_high_byte, result_low_byte, tick_count;
   adcf_state_t state;
   logic [3:0] conv_left;
   logic [15:0] accum, next_sum;
   logic [2:0] burst_pre;
   logic divider_source_clock, sar_tick, busy, conv_done, set_done, start_req, rj_end;
   logic [4:0] set_size_m1;
   logic wr_cfg, wr_ctl, wr_low, wr_high;

   assign wr_cfg = sfr_req.write && sfr_req.addr == `ADCF_ADDR_CONFIG;
   assign wr_ctl = sfr_req.write && sfr_req.addr == `ADCF_ADDR_CONTROL;
   assign wr_low = sfr_req.write && sfr_req.addr == `ADCF_ADDR_RESULT_LOW;
   assign wr_high = sfr_req.write && sfr_req.addr == `ADCF_ADDR_RESULT_HIGH;
   assign busy = state != ADCF_IDLE;

   // Start from the pin, or from a busy-bit write when the start mode field is zero.
   assign start_req = converter_enable && (convert_start
      || (wr_ctl && sfr_req.wdata[`ADCF_CTL_BUSY_BIT] && start_mode == 2'b00));

   always_comb
   begin
      case (converter_config_reg.repeat_count_select)
         2'b00: set_size_m1 = 5'h00;
         2'b01: set_size_m1 = 5'h03;
         2'b10: set_size_m1 = 5'h07;
         2'b11: set_size_m1 = 5'h0F;
         default: set_size_m1 = 5'h00;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         converter_config_reg <= `ADCF_CFG_RESET;
      end
      else if (wr_cfg)
      begin
         converter_config_reg <= sfr_req.wdata;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         converter_enable <= 1'b0;
         burst_mode_enable <= 1'b0;
         left_justify_select <= 1'b0;
         start_mode <= 2'b00;
      end
      else if (wr_ctl)
      begin
         converter_enable <= sfr_req.wdata[`ADCF_CTL_ENABLE_BIT];
         burst_mode_enable <= sfr_req.wdata[`ADCF_CTL_BURST_BIT];
         left_justify_select <= sfr_req.wdata[`ADCF_CTL_LJST_BIT];
         start_mode <= sfr_req.wdata[1:0];
      end
   end

   // The burst source is a prescaled tick, so it never runs faster than the burst clock limit.
   always_ff @(posedge mclk)
   begin
      if (reset || burst_pre == 3'(`ADCF_BURST_PRESCALE - 1))
      begin
         burst_pre <= 3'h0;
      end
      else
      begin
         burst_pre <= burst_pre + 3'h1;
      end
   end

   assign divider_source_clock = burst_mode_enable ? (burst_pre == 3'h0) : 1'b1;

   adcf_clock_divider u_divider
   (
      .mclk(mclk),
      .reset(reset),
      .run(busy),
      .source_tick(divider_source_clock),
      .divisor(converter_config_reg.sar_clock_divisor),
      .sar_tick(sar_tick)
   );

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         sar_conversion_clock <= 1'b0;
      end
      else if (sar_tick)
      begin
         sar_conversion_clock <= !sar_conversion_clock;
      end
   end

   assign conv_done = state == ADCF_CONVERT && sar_tick && tick_count == `ADCF_SAR_TICKS_PER_CONV;
   assign set_done = conv_done && conv_left == 4'h0;
   assign next_sum = accum + {4'h0, sample_code};

   // Sequencer: one conversion per start outside burst, a self-timed set in burst.
   always_ff @(posedge mclk)
   begin
      if (reset || !converter_enable)
      begin
         state <= ADCF_IDLE;
         conv_left <= 4'h0;
         tick_count <= 8'h00;
      end
      else
      begin
         case (state)
            ADCF_IDLE:
            begin
               tick_count <= 8'h00;
               if (start_req)
               begin
                  state <= ADCF_CONVERT;
                  conv_left <= set_size_m1[3:0];
               end
            end
            ADCF_CONVERT:
            begin
               if (sar_tick)
               begin
                  tick_count <= conv_done ? 8'h00 : tick_count + 8'h01;
               end
               if (set_done)
               begin
                  state <= ADCF_IDLE;
               end
               else if (conv_done)
               begin
                  conv_left <= conv_left - 4'h1;
                  state <= burst_mode_enable ? ADCF_CONVERT : ADCF_WAIT_START;
               end
            end
            ADCF_WAIT_START:
            begin
               if (start_req)
               begin
                  state <= ADCF_CONVERT;
               end
            end
            default:
            begin
               state <= ADCF_IDLE;
            end
         endcase
      end
   end

   // Accumulator restarts with each new set, so a stale sum never leaks into the next one.
   always_ff @(posedge mclk)
   begin
      if (reset || (state == ADCF_IDLE && start_req))
      begin
         accum <= 16'h0000;
      end
      else if (conv_done)
      begin
         accum <= next_sum;
      end
   end

   // Justification is sampled when the set ends; left justify with repeats keeps only sum bits 11:0.
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         result_high_byte <= `ADCF_RESULT_RESET;
         result_low_byte <= `ADCF_RESULT_RESET;
      end
      else if (set_done)
      begin
         if (left_justify_select)
         begin
            result_high_byte <= next_sum[11:4];
            result_low_byte <= {next_sum[3:0], 4'h0};
         end
         else
         begin
            case (converter_config_reg.repeat_count_select)
               2'b00: result_high_byte <= {4'h0, next_sum[11:8]};
               2'b01: result_high_byte <= {3'h0, next_sum[12:8]};
               2'b10: result_high_byte <= {2'h0, next_sum[13:8]};
               default: result_high_byte <= next_sum[15:8];
            endcase
            result_low_byte <= next_sum[7:0];
         end
      end
      else
      begin
         if (wr_high)
         begin
            result_high_byte <= sfr_req.wdata;
         end
         if (wr_low)
         begin
            result_low_byte <= sfr_req.wdata;
         end
      end
   end

   // Set wins over a clear in the same cycle.
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         conversion_done_flag <= 1'b0;
         window_flag <= 1'b0;
      end
      else
      begin
         if (set_done)
         begin
            conversion_done_flag <= 1'b1;
         end
         else if (wr_ctl)
         begin
            conversion_done_flag <= sfr_req.wdata[`ADCF_CTL_DONE_BIT];
         end
         if (set_done && window_hit)
         begin
            window_flag <= 1'b1;
         end
         else if (wr_ctl)
         begin
            window_flag <= sfr_req.wdata[`ADCF_CTL_WIN_BIT];
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         end_of_conversion_event <= 1'b0;
         window_compare_event <= 1'b0;
         gain_program_enable <= 1'b0;
         sfr_rdata <= 8'h00;
      end
      else
      begin
         end_of_conversion_event <= set_done;
         window_compare_event <= set_done && window_hit;
         gain_program_enable <= converter_config_reg.gain_program_enable;
         case (sfr_req.addr)
            `ADCF_ADDR_CONFIG: sfr_rdata <= converter_config_reg;
            `ADCF_ADDR_CONTROL: sfr_rdata <= {converter_enable, burst_mode_enable, conversion_done_flag,
               busy, window_flag, left_justify_select, start_mode};
            `ADCF_ADDR_RESULT_HIGH: sfr_rdata <= result_high_byte;
            `ADCF_ADDR_RESULT_LOW: sfr_rdata <= result_low_byte;
            default: sfr_rdata <= 8'h00;
         endcase
      end
   end

   assign rpt_code = converter_config_reg.repeat_count_select;
   assign rj_end = set_done && !left_justify_select;
   property p_eoc_sets_flag; set_done |=> conversion_done_flag && end_of_conversion_event; endproperty
   a_eoc_sets_flag: assert property (p_eoc_sets_flag) else $error("done flag not set after set end");
   property p_low_right; rj_end |=> result_low_byte == $past(next_sum[7:0]); endproperty
   a_low_right: assert property (p_low_right) else $error("low byte wrong when right justified");
   property p_low_left; set_done && left_justify_select |=> result_low_byte[3:0] == 4'h0; endproperty
   a_low_left: assert property (p_low_left) else $error("low nibble not zero when left justified");
   property p_high_rpt0; rj_end && rpt_code == 2'b00 |=> result_high_byte[7:4] == 4'h0; endproperty
   a_high_rpt0: assert property (p_high_rpt0) else $error("high byte not zero filled for code 00");
   property p_sum_clear; state == ADCF_IDLE && start_req |=> accum == 16'h0000; endproperty
   a_sum_clear: assert property (p_sum_clear) else $error("accumulator not cleared at set start");
   property p_idle_no_tick; state == ADCF_IDLE ##1 state == ADCF_IDLE |-> !sar_tick; endproperty
   a_idle_no_tick: assert property (p_idle_no_tick) else $error("divider ticks while idle");
   property p_burst_no_wait; burst_mode_enable && conv_done && !set_done |=> state == ADCF_CONVERT; endproperty
   a_burst_no_wait: assert property (p_burst_no_wait) else $error("burst set paused for start");
   property p_gain; wr_cfg |=> ##1 gain_program_enable == $past(sfr_req.wdata[0], 2); endproperty
   a_gain: assert property (p_gain) else $error("gain enable not following config bit 0");
   property p_high_rpt1; rj_end && rpt_code == 2'b01 |=> result_high_byte[7:5] == 3'h0; endproperty
   a_high_rpt1: assert property (p_high_rpt1) else $error("high byte not zero filled for code 01");
   property p_high_rpt2; rj_end && rpt_code == 2'b10 |=> result_high_byte[7:6] == 2'h0; endproperty
   a_high_rpt2: assert property (p_high_rpt2) else $error("high byte not zero filled for code 10");
   property p_high_rpt3; rj_end && rpt_code == 2'b11 |=> result_high_byte == $past(next_sum[15:8]); endproperty
   a_high_rpt3: assert property (p_high_rpt3) else $error("high byte not upper sum for code 11");
   property p_high_left; set_done && left_justify_select |=> result_high_byte == $past(next_sum[11:4]); endproperty
   a_high_left: assert property (p_high_left) else $error("high byte wrong when left justified");
   property p_eoc_at_set; end_of_conversion_event |-> $past(set_done); endproperty
   a_eoc_at_set: assert property (p_eoc_at_set) else $error("end of set event without set end");
   property p_win_with_eoc; window_compare_event |-> end_of_conversion_event; endproperty
   a_win_with_eoc: assert property (p_win_with_eoc) else $error("window event outside set end");
   property p_done_sticky; conversion_done_flag && !wr_ctl |=> conversion_done_flag; endproperty
   a_done_sticky: assert property (p_done_sticky) else $error("done flag dropped without a clear");
   property p_burst_source; burst_mode_enable && divider_source_clock && !wr_ctl |=> !divider_source_clock; endproperty
   a_burst_source: assert property (p_burst_source) else $error("burst source ticks too fast");
   c_burst_set: cover property (@(posedge mclk) burst_mode_enable && set_done
      && converter_config_reg.repeat_count_select == 2'b11);
   c_triggered_set: cover property (@(posedge mclk) !burst_mode_enable && set_done
      && converter_config_reg.repeat_count_select == 2'b01);
   c_left_justified: cover property (@(posedge mclk) set_done && left_justify_select);
endmodule

// >>> hdl/adcf_consts.svh
// Register offsets, field positions, reset values and timing counts of the converter controller.
`ifndef ADCF_CONSTS_SVH
`define ADCF_CONSTS_SVH
`define ADCF_ADDR_RESULT_LOW 8'hBD
`define ADCF_ADDR_RESULT_HIGH 8'hBE
`define ADCF_ADDR_CONFIG 8'hBC
`define ADCF_ADDR_CONTROL 8'hE8
`define ADCF_CFG_RESET 8'hF8
`define ADCF_CTL_RESET 8'h00
`define ADCF_RESULT_RESET 8'h00
`define ADCF_CFG_DIV_MSB 7
`define ADCF_CFG_DIV_LSB 3
`define ADCF_CFG_RPT_MSB 2
`define ADCF_CFG_RPT_LSB 1
`define ADCF_CFG_GAIN_BIT 0
`define ADCF_CTL_ENABLE_BIT 7
`define ADCF_CTL_BURST_BIT 6
`define ADCF_CTL_DONE_BIT 5
`define ADCF_CTL_BUSY_BIT 4
`define ADCF_CTL_WIN_BIT 3
`define ADCF_CTL_LJST_BIT 2
`define ADCF_BURST_CLK_MHZ 30
`define ADCF_SYS_CLK_MHZ 200
`define ADCF_BURST_PRESCALE (((`ADCF_SYS_CLK_MHZ) + (`ADCF_BURST_CLK_MHZ) - 1) / (`ADCF_BURST_CLK_MHZ))
`define ADCF_SAR_TICKS_PER_CONV 8'h0E
`endif

// >>> hdl/adcf_pkg.sv
// Types shared by the converter controller files.
package adcf_pkg;
   typedef struct packed
   {
      logic [4:0] sar_clock_divisor;
      logic [1:0] repeat_count_select;
      logic gain_program_enable;
   } adcf_cfg_t;

   typedef struct packed
   {
      logic write;
      logic read;
      logic [7:0] addr;
      logic [7:0] wdata;
   } adcf_sfr_req_t;

   typedef enum logic [1:0]
   {
      ADCF_IDLE,
      ADCF_CONVERT,
      ADCF_WAIT_START
   } adcf_state_t;
endpackage

// >>> hdl/adcf_clock_divider.sv
// Divider that makes the SAR conversion clock tick from a source tick.
`timescale 1ns/1ps
module adcf_clock_divider
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic run,
   input wire logic source_tick,
   input wire logic [4:0] divisor,
   output logic sar_tick
);
   logic [4:0] count;

   // The count restarts whenever the converter is idle so the first conversion of each set sees a full first period.
   always_ff @(posedge mclk)
   begin
      if (reset || !run)
      begin
         count <= 5'h00;
         sar_tick <= 1'b0;
      end
      else if (source_tick)
      begin
         if (count >= divisor)
         begin
            count <= 5'h00;
            sar_tick <= 1'b1;
         end
         else
         begin
            count <= count + 5'h01;
            sar_tick <= 1'b0;
         end
      end
      else
      begin
         sar_tick <= 1'b0;
      end
   end
endmodule

// >>> bench/adcf_converter_tb.sv
// Self-checking testbench of the converter controller.
`timescale 1ns/1ps
`include "adcf_consts.svh"
module adcf_converter_tb;
   import adcf_pkg::*;
   logic mclk;
   logic reset;
   adcf_sfr_req_t sfr_req;
   logic convert_start;
   logic [11:0] sample_code;
   logic window_hit;
   logic [7:0] sfr_rdata;
   logic end_of_conversion_event;
   logic window_compare_event;
   logic sar_conversion_clock;
   logic gain_program_enable;
   int error_cnt = 0;
   int n_checks = 0;
   int cycles = 0;

   adcf_converter i_adcf_converter
   (
      .mclk(mclk),
      .reset(reset),
      .sfr_req(sfr_req),
      .convert_start(convert_start),
      .sample_code(sample_code),
      .window_hit(window_hit),
      .sfr_rdata(sfr_rdata),
      .end_of_conversion_event(end_of_conversion_event),
      .window_compare_event(window_compare_event),
      .sar_conversion_clock(sar_conversion_clock),
      .gain_program_enable(gain_program_enable)
   );

   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // A hung handshake would otherwise stall the run forever.
   always @(posedge mclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         error_cnt++;
         $display("[FAIL] run time expected below 20000 seen 20000");
         test_done();
      end
   end

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic step();
      @(posedge mclk);
      #1;
   endtask

   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      step();
      sfr_req = '{1'b1, 1'b0, addr, data};
      step();
      sfr_req.write = 1'b0;
   endtask

   // Read data is registered, so it is looked at one edge after the address.
   task automatic rd(input logic [7:0] addr, input logic [7:0] exp, input string name);
      step();
      sfr_req.addr = addr;
      sfr_req.read = 1'b1;
      step();
      chk(name, {8'h00, exp}, {8'h00, sfr_rdata});
   endtask

   task automatic pulse();
      step();
      convert_start = 1'b1;
      step();
      convert_start = 1'b0;
   endtask

   // The second toggle interval is measured, the first may be partial.
   task automatic period(input int exp);
      logic s;
      int n;
      n = 0;
      s = sar_conversion_clock;
      while (sar_conversion_clock === s && n < 500)
      begin
         step();
         n++;
      end
      s = sar_conversion_clock;
      n = 0;
      while (sar_conversion_clock === s && n < 500)
      begin
         step();
         n++;
      end
      chk("sar clock toggle interval", 16'(exp), 16'(n));
   endtask

   task automatic wait_eoc(input logic win);
      int n;
      n = 0;
      while (end_of_conversion_event !== 1'b1 && n < 4000)
      begin
         step();
         n++;
      end
      chk("end of set event", 16'h0001, {15'h0, end_of_conversion_event});
      chk("window event", {15'h0, win}, {15'h0, window_compare_event});
      step();
      chk("end of set event width", 16'h0000, {15'h0, end_of_conversion_event});
   endtask

   task automatic conv(input logic [7:0] cfg, input logic [7:0] ctl, input int n, input logic [11:0] code,
                       input logic win, input int per, input logic bw);
      logic [15:0] exp;
      int starts;
      exp = ctl[2] ? {code, 4'h0} : 16'(n) * 16'(code);
      exp[15:8] &= (cfg[2:1] == 2'b01) ? 8'h1F : (cfg[2:1] == 2'b10) ? 8'h3F : 8'hFF;
      starts = ctl[6] ? 1 : n;
      wr(`ADCF_ADDR_CONFIG, cfg);
      wr(`ADCF_ADDR_CONTROL, ctl);
      sample_code = code;
      window_hit = win;
      for (int i = 0; i < starts; i++)
      begin
         if (bw)
            wr(`ADCF_ADDR_CONTROL, ctl | 8'h10);
         else
            pulse();
         if (i == 0 && per > 0)
            period(per);
         if (i < starts - 1)
            repeat (60) step();
      end
      rd(`ADCF_ADDR_CONTROL, ctl | 8'h10, "control while busy");
      wait_eoc(win);
      rd(`ADCF_ADDR_RESULT_HIGH, exp[15:8], "result high");
      rd(`ADCF_ADDR_RESULT_LOW, exp[7:0], "result low");
      rd(`ADCF_ADDR_CONTROL, ctl | 8'h20 | (win ? 8'h08 : 8'h00), "control after set");
      wr(`ADCF_ADDR_CONTROL, ctl);
      rd(`ADCF_ADDR_CONTROL, ctl, "control after clear");
   endtask

   initial
   begin
      reset = 1'b1;
      sfr_req = '0;
      convert_start = 1'b0;
      sample_code = 12'h000;
      window_hit = 1'b0;
      repeat (6) @(posedge mclk);
      #1 reset = 1'b0;
      rd(`ADCF_ADDR_CONFIG, `ADCF_CFG_RESET, "config reset");
      rd(`ADCF_ADDR_CONTROL, `ADCF_CTL_RESET, "control reset");
      rd(`ADCF_ADDR_RESULT_HIGH, `ADCF_RESULT_RESET, "high reset");
      rd(`ADCF_ADDR_RESULT_LOW, `ADCF_RESULT_RESET, "low reset");
      chk("gain enable reset", 16'h0000, {15'h0, gain_program_enable});
      wr(8'h55, 8'hFF);
      rd(8'h55, 8'h00, "unmapped read");
      wr(`ADCF_ADDR_RESULT_HIGH, 8'h5A);
      rd(`ADCF_ADDR_RESULT_HIGH, 8'h5A, "high write");
      wr(`ADCF_ADDR_RESULT_LOW, 8'hA5);
      rd(`ADCF_ADDR_RESULT_LOW, 8'hA5, "low write");
      wr(`ADCF_ADDR_CONTROL, 8'h81);
      wr(`ADCF_ADDR_CONTROL, 8'h91);
      rd(`ADCF_ADDR_CONTROL, 8'h81, "busy write with start mode 01");
      wr(`ADCF_ADDR_CONFIG, 8'h01);
      step();
      chk("gain enable", 16'h0001, {15'h0, gain_program_enable});
      rd(`ADCF_ADDR_CONFIG, 8'h01, "config write");
      $display("test registers done");
      conv(8'h00, 8'h80, 1, 12'hABC, 1'b0, 0, 1'b0);
      conv(8'h00, 8'h84, 1, 12'hABC, 1'b0, 0, 1'b0);
      conv(8'h00, 8'h80, 1, 12'h5A3, 1'b1, 0, 1'b1);
      $display("test formatting done");
      conv(8'h02, 8'h80, 4, 12'hFFF, 1'b0, 0, 1'b0);
      conv(8'h04, 8'hC0, 8, 12'hFFF, 1'b0, 0, 1'b0);
      conv(8'h06, 8'hC0, 16, 12'hFFF, 1'b0, 0, 1'b0);
      conv(8'h06, 8'h80, 16, 12'h001, 1'b0, 0, 1'b0);
      $display("test accumulate done");
      conv(8'h18, 8'h80, 1, 12'h123, 1'b0, 4, 1'b0);
      conv(8'h18, 8'hC0, 1, 12'h123, 1'b0, 28, 1'b0);
      $display("test divider done");
      test_done();
   end
endmodule
